/* File: pkg/lsu_decode_pkg.sv */
// Purpose: constants and carriers for the post-increment load/store decoder
// Assumes: 32-bit instructions, naturally aligned data accesses
// Notes:   encodings follow the custom opcode map of the core
package lsu_decode_pkg;

  localparam int XLEN      = 32;
  localparam int REG_IDX_W = 5;

  // instruction field positions
  localparam int OPC_LSB   = 0;
  localparam int OPC_W     = 7;
  localparam int RD_LSB    = 7;
  localparam int F3_LSB    = 12;
  localparam int F3_W      = 3;
  localparam int RS1_LSB   = 15;
  localparam int RS2_LSB   = 20;
  localparam int F7_LSB    = 25;
  localparam int F7_W      = 7;
  localparam int IMM_I_LSB = 20;
  localparam int IMM_W     = 12;
  localparam int IMM_LO_W  = 5;

  // major opcodes
  localparam logic [OPC_W-1:0] OPC_LOAD_IMM = 7'h0b;
  localparam logic [OPC_W-1:0] OPC_CUSTOM   = 7'h2b;

  // funct3 codes
  localparam logic [F3_W-1:0] F3_LB  = 3'h0;
  localparam logic [F3_W-1:0] F3_LH  = 3'h1;
  localparam logic [F3_W-1:0] F3_LW  = 3'h2;
  localparam logic [F3_W-1:0] F3_REG = 3'h3;
  localparam logic [F3_W-1:0] F3_LBU = 3'h4;
  localparam logic [F3_W-1:0] F3_LHU = 3'h5;
  localparam logic [F3_W-1:0] F3_SB  = 3'h0;
  localparam logic [F3_W-1:0] F3_SH  = 3'h1;
  localparam logic [F3_W-1:0] F3_SW  = 3'h2;

  // funct7 of register-register forms: 00 s u n zz (s store, u unsigned, n no increment)
  localparam logic [1:0] F7_TOP_ZERO = 2'h0;
  localparam int F7_STORE_BIT = 4;
  localparam int F7_UNS_BIT   = 3;
  localparam int F7_NOINC_BIT = 2;

  // access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_RSVD = 2'h3;

  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_HALF = 4'h3;
  localparam logic [3:0] BE_WORD = 4'hf;

  typedef enum logic [1:0] { OFF_IMM, OFF_RS2, OFF_RS3 } off_sel_t;

  typedef struct packed {
    logic                 legal;
    logic                 load;
    logic                 uns;
    logic                 postinc;
    logic [1:0]           size;
    off_sel_t             off_sel;
    logic [XLEN-1:0]      imm;
    logic [REG_IDX_W-1:0] rd;
    logic [REG_IDX_W-1:0] base;
  } dec_t;

  typedef struct packed {
    logic            req;
    logic            we;
    logic [3:0]      be;
    logic [XLEN-1:0] addr;
    logic [XLEN-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic                 we;
    logic [REG_IDX_W-1:0] addr;
    logic [XLEN-1:0]      data;
  } wb_t;

endpackage

/* File: rtl/postinc_load_store_decode.sv */
// Purpose: decode and execute custom post-increment / register-register loads and stores
// Assumes: register operands are valid alongside instr_valid; memory grants then answers
// Notes:   one access in flight; misaligned accesses fault without reaching memory
//
// Behaviour
// RQ1 - custom load/store forms are legal only when the custom extension parameter is 1.
// RQ2 - post-increment accesses use the unmodified base, then write base plus offset back.
// RQ3 - base always comes from a register; offset from immediate, rs2 for register loads or rs3 for register stores.
// RQ4 - immediates are sign-extended and operands treated as signed.
// RQ5 - immediate post-increment loads extend data per variant, base gains the immediate.
// RQ6 - register post-increment loads extend data per variant, base gains rs2.
// RQ7 - register loads read at rs1 plus rs2, base left unchanged.
// RQ8 - immediate post-increment stores write rs2 at rs1, base gains the immediate.
// RQ9 - register post-increment stores write rs2 at rs1, base gains rs3.
// RQ10 - register stores write rs2 at rs1 plus rs3, no register changes.
// RQ11 - event load word is legal only when the cluster parameter is 1.
// RQ12 - immediate loads: opcode 0x0b, funct3 picks signed/unsigned byte, half, word.
// RQ13 - register loads: opcode 0x2b, funct3 011, funct7 bit 2 drops the increment.
// RQ14 - immediate stores: opcode 0x2b, funct3 000/001/010, split 12-bit offset.
// RQ15 - register stores: funct7 0x10-0x12 post-increment, 0x14-0x16 plain, rs3 in 11:7.
// RQ16 - when destination equals base, loaded data wins over the incremented address.
// RQ17 - base write-back happens only when the access completes without error.
module postinc_load_store_decode
  import lsu_decode_pkg::*;
#(
  parameter bit custom_isa_enable_param = 1'b1,
  parameter bit cluster_feature_param   = 1'b1
) (
  input  wire logic            ref_clk,
  input  wire logic            resetn,
  input  wire logic            instr_valid,
  input  wire logic [XLEN-1:0] instr,
  input  wire logic [XLEN-1:0] rs1_val,
  input  wire logic [XLEN-1:0] rs2_val,
  input  wire logic [XLEN-1:0] rs3_val,
  output logic                 instr_ready_q,
  output logic                 illegal_q,
  output logic                 fault_q,
  output logic                 done_q,
  output mem_req_t             mem_q,
  input  wire logic            mem_gnt,
  input  wire logic            mem_rvalid,
  input  wire logic [XLEN-1:0] mem_rdata,
  input  wire logic            mem_err,
  output wb_t                  wb_data_q,
  output wb_t                  wb_base_q
);

  typedef enum logic [1:0] { ST_IDLE, ST_REQ, ST_RESP } state_t;

  state_t          state_q;
  dec_t            dec;
  dec_t            op_q;
  logic [XLEN-1:0] offset;
  logic [XLEN-1:0] sum;
  logic [XLEN-1:0] acc_addr;
  logic [XLEN-1:0] new_base_q;
  logic            misaligned;
  logic [3:0]      be_base;
  logic [XLEN-1:0] sh;
  logic            accept;
  logic            issue;
  logic            finish;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  always_comb begin
    logic [OPC_W-1:0] opc;
    logic [F3_W-1:0]  f3;
    logic [F7_W-1:0]  f7;
    opc = instr[OPC_LSB +: OPC_W];
    f3  = instr[F3_LSB +: F3_W];
    f7  = instr[F7_LSB +: F7_W];
    dec         = '0;
    dec.rd      = instr[RD_LSB +: REG_IDX_W];
    dec.base    = instr[RS1_LSB +: REG_IDX_W];          // [RQ3]
    dec.postinc = 1'b1;
    dec.off_sel = OFF_IMM;
    // sign-extended 12-bit immediate, i-type layout
    dec.imm = {{(XLEN-IMM_W){instr[XLEN-1]}}, instr[IMM_I_LSB +: IMM_W]}; // [RQ4]
    if (opc == OPC_LOAD_IMM) begin
      dec.load = 1'b1;
      unique case (f3)
        F3_LB:  begin dec.legal = custom_isa_enable_param; dec.size = SZ_BYTE; end // [RQ12] [RQ1]
        F3_LBU: begin dec.legal = custom_isa_enable_param; dec.size = SZ_BYTE;
                      dec.uns = 1'b1; end
        F3_LH:  begin dec.legal = custom_isa_enable_param; dec.size = SZ_HALF; end
        F3_LHU: begin dec.legal = custom_isa_enable_param; dec.size = SZ_HALF;
                      dec.uns = 1'b1; end
        F3_LW:  begin dec.legal = custom_isa_enable_param; dec.size = SZ_WORD; end
        F3_REG: begin dec.legal = cluster_feature_param; dec.size = SZ_WORD;   // [RQ11]
                      dec.postinc = 1'b0; end
        default: dec.legal = 1'b0;
      endcase
    end else if (opc == OPC_CUSTOM) begin
      if (f3 == F3_SB || f3 == F3_SH || f3 == F3_SW) begin
        // store offset split over 31:25 and 11:7
        dec.imm = {{(XLEN-IMM_W){instr[XLEN-1]}}, f7,
                   instr[RD_LSB +: IMM_LO_W]};                        // [RQ14] [RQ4]
        dec.size  = f3[1:0];
        dec.legal = custom_isa_enable_param;                          // [RQ1] [RQ8]
      end else if (f3 == F3_REG && f7[F7_W-1 -: 2] == F7_TOP_ZERO) begin
        dec.load    = !f7[F7_STORE_BIT];
        dec.uns     = f7[F7_UNS_BIT];
        dec.postinc = !f7[F7_NOINC_BIT];                              // [RQ13] [RQ15]
        dec.size    = f7[1:0];
        dec.off_sel = dec.load ? OFF_RS2 : OFF_RS3;                   // [RQ3]
        dec.legal   = custom_isa_enable_param && f7[1:0] != SZ_RSVD &&
                      !(f7[F7_UNS_BIT] && (!dec.load || f7[1:0] == SZ_WORD));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address generation
  always_comb begin
    unique case (dec.off_sel)
      OFF_RS2: offset = rs2_val;                                      // [RQ6] [RQ7]
      OFF_RS3: offset = rs3_val;                                      // [RQ9] [RQ10]
      default: offset = dec.imm;                                      // [RQ5] [RQ8]
    endcase
    sum      = rs1_val + offset;
    acc_addr = dec.postinc ? rs1_val : sum;                           // [RQ2] [RQ7] [RQ10]
    // split accesses are not supported, so these fault instead
    unique case (dec.size)
      SZ_HALF: misaligned = acc_addr[0];
      SZ_WORD: misaligned = acc_addr[1:0] != 2'h0;
      default: misaligned = 1'b0;
    endcase
    unique case (dec.size)
      SZ_HALF: be_base = BE_HALF;
      SZ_WORD: be_base = BE_WORD;
      default: be_base = BE_BYTE;
    endcase
  end

  assign accept = instr_ready_q && instr_valid;
  assign issue  = accept && dec.legal && !misaligned;
  assign finish = state_q == ST_RESP && mem_rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q       <= ST_IDLE;
      instr_ready_q <= 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: if (issue) begin
          state_q       <= ST_REQ;
          instr_ready_q <= 1'b0;
        end
        ST_REQ: if (mem_gnt) state_q <= ST_RESP;
        ST_RESP: if (mem_rvalid) begin
          state_q       <= ST_IDLE;
          instr_ready_q <= 1'b1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      illegal_q <= 1'b0;
      fault_q   <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      illegal_q <= accept && !dec.legal;                              // [RQ1] [RQ11]
      // misaligned and bus errors both fault; no write-back follows
      fault_q   <= (accept && dec.legal && misaligned) || (finish && mem_err);
      done_q    <= finish && !mem_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory request, held until granted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_q      <= '0;
      op_q       <= '0;
      new_base_q <= '0;
    end else if (issue) begin
      op_q        <= dec;
      new_base_q  <= sum;                                             // [RQ2]
      mem_q.req   <= 1'b1;
      mem_q.we    <= !dec.load;
      mem_q.addr  <= acc_addr;
      mem_q.be    <= be_base << acc_addr[1:0];
      mem_q.wdata <= rs2_val << {acc_addr[1:0], 3'h0};                // [RQ8] [RQ9] [RQ10]
    end else if (state_q == ST_REQ && mem_gnt) begin
      mem_q.req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data moved down from its byte lane
  assign sh = mem_rdata >> {mem_q.addr[1:0], 3'h0};

  ////////////////////////////////////////////////////////////////////////////
  // register write-back, one-cycle pulses
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wb_data_q <= '0;
      wb_base_q <= '0;
    end else begin
      wb_data_q.we   <= finish && !mem_err && op_q.load;              // [RQ17]
      wb_data_q.addr <= op_q.rd;
      unique case (op_q.size)
        SZ_BYTE: wb_data_q.data <= {{(XLEN-8){sh[7] && !op_q.uns}}, sh[7:0]};    // [RQ5] [RQ6]
        SZ_HALF: wb_data_q.data <= {{(XLEN-16){sh[15] && !op_q.uns}}, sh[15:0]}; // [RQ7]
        default: wb_data_q.data <= sh;
      endcase
      // loaded data takes the register when rd names the base
      wb_base_q.we   <= finish && !mem_err && op_q.postinc &&
                        !(op_q.load && op_q.rd == op_q.base);         // [RQ16] [RQ17] [RQ2]
      wb_base_q.addr <= op_q.base;
      wb_base_q.data <= new_base_q;
    end
  end

endmodule

/* File: dv/postinc_load_store_decode_props.sv */
// Purpose: concurrent checks on the load/store decoder ports
// Assumes: one clock domain, async active-low reset
// Notes:   antecedents are exercised by the bench scenarios
module postinc_load_store_decode_props
  import lsu_decode_pkg::*;
#(
  parameter bit custom_isa_enable_param = 1'b1,
  parameter bit cluster_feature_param   = 1'b1
) (
  input logic            ref_clk,
  input logic            resetn,
  input logic            instr_valid,
  input logic [XLEN-1:0] instr,
  input logic [XLEN-1:0] rs1_val,
  input logic [XLEN-1:0] rs2_val,
  input logic [XLEN-1:0] rs3_val,
  input logic            instr_ready_q,
  input logic            illegal_q,
  input logic            fault_q,
  input logic            done_q,
  input mem_req_t        mem_q,
  input logic            mem_gnt,
  input logic            mem_rvalid,
  input wb_t             wb_data_q,
  input wb_t             wb_base_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence take_s;
    instr_valid && instr_ready_q;
  endsequence
  sequence reg_form_s(logic [6:0] f7);
    take_s ##0 (custom_isa_enable_param && instr[6:0] == OPC_CUSTOM &&
      instr[14:12] == F3_REG && instr[31:25] == f7);
  endsequence
  a_unknown_opc: assert property (take_s ##0 (instr[6:0] != OPC_LOAD_IMM &&
    instr[6:0] != OPC_CUSTOM) |=> illegal_q) else $error("unknown opcode not refused");
  a_event_gate: assert property (take_s ##0 (instr[6:0] == OPC_LOAD_IMM &&
    instr[14:12] == F3_REG) |=> illegal_q == !cluster_feature_param) else $error("event gate");
  a_postinc_addr: assert property (take_s ##0 (custom_isa_enable_param &&
    instr[6:0] == OPC_LOAD_IMM &&
    instr[14:12] == F3_LB) |=> mem_q.req && mem_q.addr == $past(rs1_val))
    else $error("post-increment access not at base");
  a_noinc_ld: assert property (reg_form_s(7'h04) |=> mem_q.req && !mem_q.we &&
    mem_q.addr == $past(rs1_val) + $past(rs2_val)) else $error("register load address");
  a_noinc_st: assert property (reg_form_s(7'h14) |=> mem_q.req && mem_q.we &&
    mem_q.addr == $past(rs1_val) + $past(rs3_val)) else $error("register store address");
  a_req_stable: assert property (mem_q.req && !mem_gnt |=> $stable(mem_q))
    else $error("request changed before grant");
  a_resp_end: assert property (!instr_ready_q && !mem_q.req && mem_rvalid
    |=> (done_q ^ fault_q) && instr_ready_q) else $error("response not closed");
  a_fault_no_wb: assert property (fault_q |-> !wb_base_q.we && !wb_data_q.we)
    else $error("write-back on fault");
  a_same_reg: assert property (wb_base_q.we && wb_data_q.we |->
    wb_base_q.addr != wb_data_q.addr) else $error("two writes to one register");
endmodule
bind postinc_load_store_decode postinc_load_store_decode_props #(
  .custom_isa_enable_param(custom_isa_enable_param),
  .cluster_feature_param(cluster_feature_param)
) u_props (.ref_clk, .resetn, .instr_valid, .instr, .rs1_val, .rs2_val, .rs3_val,
  .instr_ready_q, .illegal_q, .fault_q, .done_q, .mem_q, .mem_gnt, .mem_rvalid,
  .wb_data_q, .wb_base_q);

/* File: dv/data_mem_model.sv */
// Purpose: data memory responder facing the decoder
// Assumes: one outstanding request, grant then answer a cycle later
// Notes:   read lanes are invalid outside the answer cycle
module data_mem_model
  import lsu_decode_pkg::*;
(
  input  logic            ref_clk,
  input  logic            resetn,
  input  mem_req_t        mem_q,
  input  logic [1:0]      dly,
  input  logic            err_en,
  output logic            mem_gnt,
  output logic            mem_rvalid,
  output logic [XLEN-1:0] mem_rdata,
  output logic            mem_err
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [XLEN-1:0] RD_WORD = 32'h8180_f1f2;
  logic [1:0] wait_q;
  ////////////////////////////////////////////////////////////////////////////////
  // inverted word outside the answer, so stale data cannot pass for valid
  assign mem_rdata = mem_rvalid ? RD_WORD : ~RD_WORD;
  assign mem_err   = mem_rvalid & err_en;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_gnt    <= 1'b0;
      mem_rvalid <= 1'b0;
      wait_q     <= 2'h0;
    end else begin
      mem_rvalid <= mem_q.req && mem_gnt;
      wait_q     <= (mem_q.req && !mem_gnt) ? wait_q + 2'h1 : 2'h0;
      mem_gnt    <= mem_q.req && !mem_gnt && wait_q >= dly;
    end
  end
endmodule

/* File: dv/postinc_load_store_decode_bench.sv */
// Purpose: directed scenarios for the post-increment load/store decoder
// Assumes: memory model answers with a fixed word
// Notes:   base reg 1, source 2, dest/offset reg 3
module postinc_load_store_decode_bench
  import lsu_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, resetn = 1'b0, instr_valid = 1'b0, err_en = 1'b0;
  logic [XLEN-1:0] instr = '0, rs1_val = '0, rs2_val = '0, rs3_val = '0, ca, cd, mem_rdata;
  logic instr_ready_q, illegal_q, fault_q, done_q, mem_gnt, mem_rvalid, mem_err, cw;
  logic [1:0] dly = 2'h0;
  logic [3:0] cb;
  logic [2:0] fl;
  logic off_illegal, off_hit;
  mem_req_t mem_q;
  wb_t wb_data_q, wb_base_q, wd, wbb;
  int n_fail = 0, check_count = 0;
  logic [31:0] ld_exp [5] = '{32'hffff_fff2, 32'h0000_00f2, 32'hffff_f1f2, 32'h0000_f1f2,
                              32'h8180_f1f2};
  postinc_load_store_decode uut (.ref_clk, .resetn, .instr_valid, .instr, .rs1_val,
    .rs2_val, .rs3_val, .instr_ready_q, .illegal_q, .fault_q, .done_q, .mem_q, .mem_gnt,
    .mem_rvalid, .mem_rdata, .mem_err, .wb_data_q, .wb_base_q);
  // both extensions off: every instruction must be refused
  postinc_load_store_decode #(
    .custom_isa_enable_param(1'b0),
    .cluster_feature_param  (1'b0)
  ) uut_off (.ref_clk, .resetn, .instr_valid, .instr, .rs1_val, .rs2_val, .rs3_val,
    .instr_ready_q(), .illegal_q(off_illegal), .fault_q(), .done_q(), .mem_q(),
    .mem_gnt(1'b0), .mem_rvalid(1'b0), .mem_rdata('0), .mem_err(1'b0),
    .wb_data_q(), .wb_base_q());
  data_mem_model mem (.ref_clk, .resetn, .mem_q, .dly, .err_en, .mem_gnt, .mem_rvalid,
    .mem_rdata, .mem_err);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // sampling at the falling edge keeps clear of the launching edge
  task automatic go(input logic [31:0] i, a, b, c);
    logic hit;
    hit = 1'b0;
    off_hit = 1'b0;
    ca = '1;
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr <= i;
    rs1_val <= a;
    rs2_val <= b;
    rs3_val <= c;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    repeat (40) if (!hit) begin
      @(negedge ref_clk);
      if (off_illegal === 1'b1) off_hit = 1'b1;
      if ((mem_q.req & mem_gnt) === 1'b1) begin
        ca = mem_q.addr;
        cw = mem_q.we;
        cb = mem_q.be;
        cd = mem_q.wdata;
      end
      if ((done_q | fault_q | illegal_q) === 1'b1) begin
        hit = 1'b1;
        fl = {done_q, fault_q, illegal_q};
        wd = wb_data_q;
        wbb = wb_base_q;
      end
    end
    chk("outcome", 32'h3, {30'h0, instr_ready_q, hit});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_ld;
    logic [2:0] f3 [5] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2};
    logic [6:0] f7 [5] = '{7'h00, 7'h08, 7'h01, 7'h09, 7'h02};
    for (int k = 0; k < 5; k++) begin
      go({12'hffc, 5'd1, f3[k], 5'd3, OPC_LOAD_IMM}, 32'h100, '0, '0);
      chk("ld_addr", 32'h100, ca);
      chk("ld_data", ld_exp[k], wd.data);
      chk("ld_base", {1'b1, 31'hfc}, {wbb.we, wbb.data[30:0]});
      chk("ld_regs", 32'h0301, {19'h0, wd.addr, 3'h0, wbb.addr});
      chk("off_ld", 32'h1, {31'h0, off_hit});
      for (int j = 0; j < 2; j++) begin
        go({f7[k] | 7'(j << 2), 5'd2, 5'd1, F3_REG, 5'd3, OPC_CUSTOM}, 32'h100, 32'h10, '0);
        chk("rr_addr", j ? 32'h110 : 32'h100, ca);
        chk("rr_data", ld_exp[k], wd.data);
        chk("rr_base", {31'h0, !j}, {31'h0, wbb.we});
        if (j == 0) chk("rr_base_val", 32'h110, wbb.data);
      end
    end
    $display("t_ld done");
  endtask
  task automatic t_st;
    logic [31:0] m [3] = '{32'hff, 32'hffff, 32'hffff_ffff};
    logic [3:0] be [3] = '{BE_BYTE, BE_HALF, BE_WORD};
    for (int k = 0; k < 3; k++) begin
      go({7'h40, 5'd2, 5'd1, 3'(k), 5'h04, OPC_CUSTOM}, 32'h1000, 32'h1122_3344, '0);
      chk("si_addr", 32'h1000, ca);
      chk("si_ctl", {27'h0, be[k], 1'b1}, {27'h0, cb, cw});
      chk("si_data", 32'h1122_3344 & m[k], cd & m[k]);
      chk("si_base", {1'b1, 31'h804}, {wbb.we, wbb.data[30:0]});
      chk("off_st", 32'h1, {31'h0, off_hit});
      for (int j = 0; j < 2; j++) begin
        go({7'h10 + 7'(k + 4 * j), 5'd2, 5'd1, F3_REG, 5'd3, OPC_CUSTOM}, 32'h1000,
           32'h1122_3344, 32'h20);
        chk("sr_addr", j ? 32'h1020 : 32'h1000, ca);
        chk("sr_data", 32'h1122_3344 & m[k], cd & m[k]);
        chk("sr_base", {31'h0, !j}, {31'h0, wbb.we});
        if (j == 0) chk("sr_base_val", 32'h1020, wbb.data);
      end
    end
    $display("t_st done");
  endtask
  task automatic t_misc;
    dly <= 2'h3;
    err_en <= 1'b1;
    go({12'h004, 5'd1, F3_LW, 5'd3, OPC_LOAD_IMM}, 32'h100, '0, '0);
    chk("err_flags", 32'h2, {29'h0, fl});
    chk("err_wb", 32'h0, {30'h0, wd.we, wbb.we});
    err_en <= 1'b0;
    go({12'h004, 5'd1, F3_LW, 5'd1, OPC_LOAD_IMM}, 32'h100, '0, '0);
    chk("same_we", 32'h2, {30'h0, wd.we, wbb.we});
    chk("same_data", 32'h8180_f1f2, wd.data);
    go({12'h004, 5'd1, F3_REG, 5'd3, OPC_LOAD_IMM}, 32'h100, '0, '0);
    chk("ev_addr", 32'h104, ca);
    chk("ev_wb", 32'h2, {30'h0, wd.we, wbb.we});
    chk("off_ev", 32'h1, {31'h0, off_hit});
    go({25'h0, 7'h33}, '0, '0, '0);
    chk("bad_opc", 32'h1, {29'h0, fl});
    go({17'h0, 3'h4, 5'h0, OPC_CUSTOM}, '0, '0, '0);
    chk("bad_f3", 32'h1, {29'h0, fl});
    $display("t_misc done");
  endtask
  // byte lanes away from offset zero, misaligned and reserved forms
  task automatic t_lane;
    go({12'h000, 5'd1, F3_LH, 5'd3, OPC_LOAD_IMM}, 32'h101, '0, '0);
    chk("mis_flags", 32'h2, {29'h0, fl});
    chk("mis_wb", 32'h0, {30'h0, wd.we, wbb.we});
    chk("mis_noreq", 32'hffff_ffff, ca);
    go({12'h000, 5'd1, F3_LH, 5'd3, OPC_LOAD_IMM}, 32'h102, '0, '0);
    chk("lane_ld", 32'hffff_8180, wd.data);
    chk("lane_be", 32'hc, {28'h0, cb});
    go({7'h00, 5'd2, 5'd1, F3_SB, 5'h00, OPC_CUSTOM}, 32'h1003, 32'h1122_3344, '0);
    chk("lane_st", 32'h4400_0008, {cd[31:24], 20'h0, cb});
    go({7'h18, 5'd2, 5'd1, F3_REG, 5'd3, OPC_CUSTOM}, '0, '0, '0);
    chk("bad_f7", 32'h1, {29'h0, fl});
    $display("t_lane done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    t_ld();
    t_st();
    t_misc();
    t_lane();
    end_sim();
  end
  initial begin
    repeat (6000) @(posedge ref_clk);
    n_fail++;
    end_sim();
  end
endmodule
